// *** hdl/dmw_pkg.sv ***
// Purpose: Shared constants and types of the mode-word decoder.
// Assumes: Field codes follow the usual double-data-rate mode layout.
// Notes: All users write dmw_pkg::name; nothing is imported.
package dmw_pkg;

  // ****************************************************************
  // Mode word layout
  // ****************************************************************
  localparam int MODE_W = 17;
  localparam int BURST_LEN_LSB = 0;
  localparam int BURST_ORDER_BIT = 3;
  localparam int LATENCY_LSB = 4;
  localparam int TEST_SELECT_BIT = 7;
  localparam int LOOP_RESET_BIT = 8;
  localparam int RECOVERY_LSB = 9;
  localparam int EXIT_STYLE_BIT = 12;
  localparam int TOP_RESERVED_BIT = 16;

  // ****************************************************************
  // Field codes and reset values
  // ****************************************************************
  localparam logic [2:0] BURST_LEN_FOUR = 3'h2;
  localparam logic [2:0] BURST_LEN_EIGHT = 3'h3;
  localparam logic [2:0] LATENCY_MIN = 3'h3;
  localparam logic [2:0] RECOVERY_MIN_CODE = 3'h1;
  localparam logic [2:0] ADD_LAT_MAX = 3'h6;
  localparam logic [2:0] RST_BURST_LEN = BURST_LEN_FOUR;
  localparam logic [2:0] RST_LATENCY = LATENCY_MIN;
  localparam logic [2:0] RST_RECOVERY = RECOVERY_MIN_CODE;

  // ****************************************************************
  // Timing counts and column width
  // ****************************************************************
  localparam int FAST_EXIT_CYCLES = 2;
  localparam int SLOW_EXIT_CYCLES = 7;
  localparam int COL_W = 10;

  // A column command as registered, before or after additive latency.
  typedef struct packed {
    logic valid;
    logic is_write;
    logic auto_pre;
    logic [COL_W-1:0] col;
  } dmw_cmd_t;

  // One column beat handed to the array side.
  typedef struct packed {
    logic is_write;
    logic last;
    logic [COL_W-1:0] col;
  } dmw_beat_t;

endpackage

// *** hdl/dmw_burst_order.sv ***
// Purpose: Column order of one beat within a burst.
// Assumes: Beat index runs 0 to 3 for four and 0 to 7 for eight.
// Notes: Purely combinational.
`timescale 1ns/1ps
`default_nettype none
module dmw_burst_order (
  input wire logic [2:0] start_in,
  input wire logic [2:0] beat_in,
  input wire logic len8_in,
  input wire logic interleave_in,
  output logic [2:0] low_out
);

  // ****************************************************************
  // Order generation
  // ****************************************************************

  // Sequential walks the nibble, then the other nibble; interleaved XORs.
  always_comb begin
    logic [1:0] nib;
    nib = 2'(start_in[1:0] + beat_in[1:0]);
    if (interleave_in) begin
      low_out = start_in ^ {beat_in[2] & len8_in, beat_in[1:0]};
    end else begin
      low_out = {start_in[2] ^ (beat_in[2] & len8_in), nib};
    end
  end

endmodule
`default_nettype wire

// *** hdl/dmw_two_entry_buf.sv ***
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: One clock; the head entry drives the output directly.
// Notes: Input ready depends only on flops, never on the output side.
`timescale 1ns/1ps
`default_nettype none
module dmw_two_entry_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk_in,
  input wire logic reset_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);

  // The head and spare structure serves exactly two entries.
  if (DEPTH != 2) begin : g_bad_depth
    $error("dmw_two_entry_buf supports DEPTH of 2 only.");
  end

  logic [WIDTH-1:0] spare;
  logic spare_valid;
  logic push;
  logic pop;

  assign in_ready_out = !spare_valid;
  assign push = in_valid_in && !spare_valid;
  assign pop = out_valid_out && out_ready_in;

  // ****************************************************************
  // Storage
  // ****************************************************************

  // The head refills from the spare first so that order is kept.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      out_valid_out <= 1'b0;
      out_data_out <= '0;
      spare_valid <= 1'b0;
      spare <= '0;
    end else if (pop || !out_valid_out) begin
      if (spare_valid) begin
        out_data_out <= spare;
        out_valid_out <= 1'b1;
        spare_valid <= push;
        if (push) begin
          spare <= in_data_in;
        end
      end else begin
        out_valid_out <= push;
        if (push) begin
          out_data_out <= in_data_in;
        end
      end
    end else if (push) begin
      spare <= in_data_in;
      spare_valid <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// *** hdl/dmw_mode_decode.sv ***
// Purpose: Mode-setting word of a DDR2 memory and the logic it steers.
// Assumes: Commands arrive already decoded and synchronous to mclk_in.
// Notes: Column beats leave through a two-entry buffer one per cycle.
`timescale 1ns/1ps
`default_nettype none
module dmw_mode_decode #(
  parameter int FAST_EXIT = dmw_pkg::FAST_EXIT_CYCLES,
  parameter int SLOW_EXIT = dmw_pkg::SLOW_EXIT_CYCLES
) (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic load_mode_command_in,
  input wire logic [dmw_pkg::MODE_W-1:0] mode_setting_word_in,
  input wire logic [2:0] additive_latency_in,
  input wire logic read_cmd_in,
  input wire logic write_cmd_in,
  input wire logic auto_precharge_in,
  input wire logic [dmw_pkg::COL_W-1:0] col_addr_in,
  input wire logic col_ready_in,
  input wire logic power_down_in,
  input wire logic banks_idle_in,
  output logic col_valid_out,
  output dmw_pkg::dmw_beat_t col_beat_out,
  output logic read_data_start_out,
  output logic precharge_out,
  output logic loop_reset_out,
  output logic test_mode_out,
  output logic burst_len8_out,
  output logic interleave_out,
  output logic [2:0] read_latency_cycles_out,
  output logic [3:0] recovery_cycles_out,
  output logic exit_slow_out,
  output logic low_power_state_out,
  output logic exit_busy_out,
  output logic mode_reserved_out
);

  localparam int PIPE_D = 8;
  localparam int EXIT_W = 8;

  // Both exit counts must be at least one cycle; the slow count must fit the exit counter.
  if (FAST_EXIT < 1 || SLOW_EXIT < 1 || SLOW_EXIT > 255) begin : g_bad
    $error("dmw_mode_decode exit counts out of range.");
  end

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BURST = 2'b10
  } dmw_state_t;

  dmw_state_t state;
  dmw_state_t next_state;
  logic [2:0] len_field;
  logic [2:0] lat_field;
  logic [2:0] rec_field;
  logic order_bit;
  logic exit_bit;
  logic [2:0] add_lat;
  dmw_pkg::dmw_cmd_t cmd_in;
  dmw_pkg::dmw_cmd_t cmd_pipe [PIPE_D];
  dmw_pkg::dmw_cmd_t cmd_int;
  dmw_pkg::dmw_cmd_t cur;
  dmw_pkg::dmw_cmd_t pending;
  logic [6:0] rd_pipe;
  logic [2:0] beat;
  logic [2:0] low_col;
  logic last_beat;
  logic buf_ready;
  logic beat_push;
  logic beat_done;
  dmw_pkg::dmw_beat_t beat_word;
  logic [3:0] wr_count;
  logic pd_q;
  logic pd_active;
  logic [EXIT_W-1:0] exit_count;

  // ****************************************************************
  // Mode word load
  // ****************************************************************

  // A load with the test bit set changes no field, only the test mode.
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      len_field <= dmw_pkg::RST_BURST_LEN;
      lat_field <= dmw_pkg::RST_LATENCY;
      rec_field <= dmw_pkg::RST_RECOVERY;
      order_bit <= 1'b0;
      exit_bit <= 1'b0;
      test_mode_out <= 1'b0;
    end else if (load_mode_command_in) begin
      test_mode_out <= mode_setting_word_in[dmw_pkg::TEST_SELECT_BIT];
      if (!mode_setting_word_in[dmw_pkg::TEST_SELECT_BIT]) begin
        len_field <= mode_setting_word_in[dmw_pkg::BURST_LEN_LSB +: 3];
        order_bit <= mode_setting_word_in[dmw_pkg::BURST_ORDER_BIT];
        lat_field <= mode_setting_word_in[dmw_pkg::LATENCY_LSB +: 3];
        rec_field <= mode_setting_word_in[dmw_pkg::RECOVERY_LSB +: 3];
        exit_bit <= mode_setting_word_in[dmw_pkg::EXIT_STYLE_BIT];
      end
    end
  end

  // The loop reset bit is never stored: it acts once and reads as zero.
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      loop_reset_out <= 1'b0;
    end else begin
      loop_reset_out <= load_mode_command_in &&
        !mode_setting_word_in[dmw_pkg::TEST_SELECT_BIT] &&
        mode_setting_word_in[dmw_pkg::LOOP_RESET_BIT];
    end
  end

  // ****************************************************************
  // Decoded fields
  // ****************************************************************

  // Reserved codes fall back to the nearest legal setting, except burst length, which always falls back to four; all are flagged.
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      burst_len8_out <= 1'b0;
      interleave_out <= 1'b0;
      read_latency_cycles_out <= dmw_pkg::LATENCY_MIN;
      recovery_cycles_out <= 4'h2;
      exit_slow_out <= 1'b0;
      mode_reserved_out <= 1'b0;
    end else begin
      burst_len8_out <= (len_field == dmw_pkg::BURST_LEN_EIGHT);
      interleave_out <= order_bit;
      read_latency_cycles_out <= (lat_field < dmw_pkg::LATENCY_MIN) ?
        dmw_pkg::LATENCY_MIN : lat_field;
      recovery_cycles_out <= (rec_field < dmw_pkg::RECOVERY_MIN_CODE) ?
        4'h2 : 4'({1'b0, rec_field} + 4'h1);
      exit_slow_out <= exit_bit;
      mode_reserved_out <= (len_field != dmw_pkg::BURST_LEN_FOUR &&
        len_field != dmw_pkg::BURST_LEN_EIGHT) ||
        (lat_field < dmw_pkg::LATENCY_MIN) ||
        (rec_field < dmw_pkg::RECOVERY_MIN_CODE);
    end
  end

  // ****************************************************************
  // Additive latency
  // ****************************************************************

  assign add_lat = (additive_latency_in > dmw_pkg::ADD_LAT_MAX) ?
    dmw_pkg::ADD_LAT_MAX : additive_latency_in;

  // Incoming column command; a read wins if both strobes are set.
  always_comb begin
    cmd_in.valid = read_cmd_in || write_cmd_in;
    cmd_in.is_write = write_cmd_in && !read_cmd_in;
    cmd_in.auto_pre = auto_precharge_in;
    cmd_in.col = col_addr_in;
  end

  // Commands wait here so they are registered additive-latency later.
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      for (int i = 0; i < PIPE_D; i++) begin
        cmd_pipe[i] <= '0;
      end
    end else begin
      cmd_pipe[0] <= cmd_in;
      for (int i = 1; i < PIPE_D; i++) begin
        cmd_pipe[i] <= cmd_pipe[i-1];
      end
    end
  end

  assign cmd_int = (add_lat == 3'h0) ? cmd_in : cmd_pipe[add_lat-3'h1];

  // ****************************************************************
  // Read latency
  // ****************************************************************

  // Internal reads travel here until the read latency has passed.
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      rd_pipe <= '0;
    end else begin
      rd_pipe <= {rd_pipe[5:0], cmd_int.valid && !cmd_int.is_write};
    end
  end

  // First data is due at edge n plus additive plus read latency.
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      read_data_start_out <= 1'b0;
    end else begin
      read_data_start_out <= rd_pipe[read_latency_cycles_out - 3'h1];
    end
  end

  // ****************************************************************
  // Burst column sequencing
  // ****************************************************************

  dmw_burst_order u_order (
    .start_in(cur.col[2:0]),
    .beat_in(beat),
    .len8_in(burst_len8_out),
    .interleave_in(interleave_out),
    .low_out(low_col)
  );

  // Block bits stay fixed so the burst wraps in its aligned block.
  always_comb begin
    last_beat = (beat == (burst_len8_out ? 3'h7 : 3'h3));
    beat_push = (state == ST_BURST);
    beat_done = beat_push && buf_ready;
    beat_word.is_write = cur.is_write;
    beat_word.last = last_beat;
    beat_word.col = {cur.col[dmw_pkg::COL_W-1:3], low_col};
  end

  // Next state: a waiting command follows a finished burst at once.
  always_comb begin
    case (state)
      ST_IDLE: begin
        next_state = (cmd_int.valid || pending.valid) ? ST_BURST : ST_IDLE;
      end
      ST_BURST: begin
        if (beat_done && last_beat && !cmd_int.valid && !pending.valid) begin
          next_state = ST_IDLE;
        end else begin
          next_state = ST_BURST;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Current burst, its beat index, and one waiting command.
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      cur <= '0;
      pending <= '0;
      beat <= 3'h0;
    end else begin
      if (state == ST_IDLE) begin
        beat <= 3'h0;
        if (pending.valid) begin
          cur <= pending;
          pending <= cmd_int;
        end else if (cmd_int.valid) begin
          cur <= cmd_int;
        end
      end else if (beat_done && last_beat) begin
        beat <= 3'h0;
        if (pending.valid) begin
          cur <= pending;
          pending <= cmd_int;
        end else begin
          cur <= cmd_int;
        end
      end else begin
        if (beat_done) begin
          beat <= 3'(beat + 3'h1);
        end
        if (cmd_int.valid) begin
          pending <= cmd_int;
        end
      end
    end
  end

  dmw_two_entry_buf #(
    .WIDTH($bits(dmw_pkg::dmw_beat_t)),
    .DEPTH(2)
  ) u_buf (
    .clk_in(mclk_in),
    .reset_in(reset_in),
    .in_valid_in(beat_push),
    .in_data_in(beat_word),
    .in_ready_out(buf_ready),
    .out_valid_out(col_valid_out),
    .out_data_out(col_beat_out),
    .out_ready_in(col_ready_in)
  );

  // ****************************************************************
  // Write recovery before auto-precharge
  // ****************************************************************

  // Counting starts when the last write column leaves the sequencer.
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      wr_count <= 4'h0;
      precharge_out <= 1'b0;
    end else begin
      precharge_out <= (wr_count == 4'h1);
      if (beat_done && last_beat && cur.is_write && cur.auto_pre) begin
        wr_count <= recovery_cycles_out;
      end else if (wr_count != 4'h0) begin
        wr_count <= 4'(wr_count - 4'h1);
      end
    end
  end

  // ****************************************************************
  // Active power-down exit
  // ****************************************************************

  // Entry with banks open makes it active power-down.
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      pd_q <= 1'b0;
      pd_active <= 1'b0;
    end else begin
      pd_q <= power_down_in;
      if (power_down_in && !pd_q) begin
        pd_active <= !banks_idle_in;
      end
    end
  end

  // Slow exit freezes the loop; fast exit keeps it running.
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      low_power_state_out <= 1'b0;
    end else begin
      low_power_state_out <= power_down_in && pd_q && pd_active &&
        exit_bit;
    end
  end

  // Exit busy stays high for the exit delay that the exit style selects; reads are not held here.
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      exit_count <= '0;
      exit_busy_out <= 1'b0;
    end else begin
      if (!power_down_in && pd_q && pd_active) begin
        exit_count <= exit_bit ? EXIT_W'(SLOW_EXIT) :
          EXIT_W'(FAST_EXIT);
        exit_busy_out <= 1'b1;
      end else if (exit_count > EXIT_W'(1)) begin
        exit_count <= EXIT_W'(exit_count - EXIT_W'(1));
      end else begin
        exit_count <= '0;
        exit_busy_out <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// *** test/dmw_ctl_model.sv ***
// Purpose: Memory controller model that feeds the mode-word decoder.
// Assumes: All requests change just after a falling clock edge.
// Notes: Released strobes drop to zero; the other command lines show the inverse of their last value.
`timescale 1ns/1ps
`default_nettype none
module dmw_ctl_model (
  input wire logic mclk_in,
  input wire logic stall_in,
  output logic load_out,
  output logic [16:0] word_out,
  output logic rd_out,
  output logic wr_out,
  output logic ap_out,
  output logic [9:0] col_out,
  output logic ready_out
);
  logic [7:0] since_lr = 8'hff;
  logic tick = 1'b0;
  // All command lines start idle.
  initial begin
    load_out = 1'b0;
    word_out = '0;
    rd_out = 1'b0;
    wr_out = 1'b0;
    ap_out = 1'b0;
    col_out = '0;
  end
  // A stalling consumer takes a beat only on every other cycle.
  always @(negedge mclk_in) begin
    tick <= ~tick;
    ready_out <= !stall_in || tick;
  end
  // Cycles since the last loop reset request, saturating.
  always @(posedge mclk_in) begin
    if (load_out && word_out[8])
      since_lr <= 8'h00;
    else if (since_lr != 8'hff)
      since_lr <= since_lr + 8'h01;
  end
  // Rounds a recovery time in ns up to whole 5 ns clocks, as a field code.
  function automatic logic [2:0] wr_code(input int t_ns);
    return 3'((t_ns + 4) / 5 - 1);
  endfunction
  // Loads a whole word, then waits out the load delay.
  task automatic load(input logic [16:0] w);
    @(negedge mclk_in);
    load_out = 1'b1;
    word_out = w;
    @(negedge mclk_in);
    load_out = 1'b0;
    word_out = ~w;
    repeat (2) @(negedge mclk_in);
  endtask
  // Issues one column command; reads wait for the loop to settle.
  task automatic col_cmd(input logic wr, input logic ap, input logic [9:0] c);
    while (!wr && since_lr < 8'd200) @(negedge mclk_in);
    @(negedge mclk_in);
    rd_out = !wr;
    wr_out = wr;
    ap_out = ap;
    col_out = c;
    @(negedge mclk_in);
    rd_out = 1'b0;
    wr_out = 1'b0;
    ap_out = ~ap;
    col_out = ~c;
  endtask
endmodule
`default_nettype wire

// *** test/dmw_mode_decode_sva.sv ***
// Purpose: Port checks of the mode-word decoder.
// Assumes: One clock domain with an active high reset.
// Notes: Attached to every instance of the decoder by the bind below.
`timescale 1ns/1ps
`default_nettype none
module dmw_mode_decode_sva (
  input wire logic mclk_in,
  input wire logic reset_in,
  input wire logic load_mode_command_in,
  input wire logic [dmw_pkg::MODE_W-1:0] mode_setting_word_in,
  input wire logic col_ready_in,
  input wire logic col_valid_out,
  input wire dmw_pkg::dmw_beat_t col_beat_out,
  input wire logic precharge_out,
  input wire logic loop_reset_out,
  input wire logic test_mode_out,
  input wire logic burst_len8_out,
  input wire logic interleave_out,
  input wire logic [2:0] read_latency_cycles_out,
  input wire logic [3:0] recovery_cycles_out,
  input wire logic exit_slow_out,
  input wire logic low_power_state_out
);
  logic ld;
  logic [16:0] w;
  logic [9:0] f;
  // ****************************************************************
  // Short names for the load strobe, the word and the decodes
  // ****************************************************************
  assign ld = load_mode_command_in;
  assign w = mode_setting_word_in;
  assign f = {burst_len8_out, interleave_out, read_latency_cycles_out,
    recovery_cycles_out, exit_slow_out};
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (reset_in);
  // ****************************************************************
  // Decodes two cycles after a normal load
  // ****************************************************************
  AST_LEN: assert property (ld && !w[7] |-> ##2
    burst_len8_out == ($past(w[2:0], 2) == 3'h3))
    else $error("burst length decode wrong");
  AST_ORDER: assert property (ld && !w[7] |-> ##2
    interleave_out == $past(w[3], 2)) else $error("order decode wrong");
  AST_LATENCY: assert property (ld && !w[7] && w[6:4] >= 3'h3 |->
    ##2 read_latency_cycles_out == $past(w[6:4], 2))
    else $error("latency decode wrong");
  AST_RECOVERY: assert property (ld && !w[7] && w[11:9] != 3'h0 |->
    ##2 recovery_cycles_out == {1'b0, $past(w[11:9], 2)} + 4'h1)
    else $error("recovery decode wrong");
  AST_EXIT: assert property (ld && !w[7] |-> ##2
    exit_slow_out == $past(w[12], 2)) else $error("exit style wrong");
  // ****************************************************************
  // Loop reset, test mode, beat hold and frozen loop
  // ****************************************************************
  AST_LOOP_PULSE: assert property (ld && w[8] && !w[7] |=>
    loop_reset_out) else $error("loop reset missing");
  AST_LOOP_CLEAR: assert property (loop_reset_out && !(ld && w[8])
    |=> !loop_reset_out) else $error("loop reset stuck");
  AST_TEST_KEEP: assert property (ld && w[7] |=> test_mode_out &&
    !loop_reset_out ##1 $stable(f)) else $error("test load changed fields");
  AST_BEAT_HOLD: assert property (col_valid_out && !col_ready_in |=>
    col_valid_out && $stable(col_beat_out)) else $error("beat dropped");
  AST_FROZEN: assert property (low_power_state_out |->
    exit_slow_out) else $error("loop frozen in fast exit");
  // Main scenarios reached.
  COV_TEST: cover property (ld && w[7]);
  COV_LAST: cover property (col_valid_out && col_beat_out.last);
  COV_PRE: cover property (precharge_out);
endmodule
bind dmw_mode_decode dmw_mode_decode_sva dmw_mode_decode_sva_i (
  .mclk_in(mclk_in), .reset_in(reset_in),
  .load_mode_command_in(load_mode_command_in),
  .mode_setting_word_in(mode_setting_word_in), .col_ready_in(col_ready_in),
  .col_valid_out(col_valid_out), .col_beat_out(col_beat_out),
  .precharge_out(precharge_out), .loop_reset_out(loop_reset_out),
  .test_mode_out(test_mode_out), .burst_len8_out(burst_len8_out),
  .interleave_out(interleave_out),
  .read_latency_cycles_out(read_latency_cycles_out),
  .recovery_cycles_out(recovery_cycles_out), .exit_slow_out(exit_slow_out),
  .low_power_state_out(low_power_state_out));
`default_nettype wire

// *** test/dmw_mode_decode_tb.sv ***
// Purpose: Self-checking bench of the mode-word decoder.
// Assumes: Inputs change on the falling clock edge.
// Notes: The slow exit delay is shortened through the design parameters.
`timescale 1ns/1ps
`default_nettype none
module dmw_mode_decode_tb;
  localparam int FAST = 2;
  localparam int SLOW = 5;
  logic clk, rst, pd, idle, stall, ld, rd, wr, ap, rdy, cv, rds, pre, lr, tm;
  logic l8, il, es, lps, eb, rsv;
  logic [2:0] al, lat;
  logic [3:0] rec;
  logic [16:0] word;
  logic [9:0] col;
  logic [2:0] lo, b;
  logic [15:0] dec;
  dmw_pkg::dmw_beat_t beat;
  dmw_pkg::dmw_beat_t q[$];
  int n_fail = 0, n_compared = 0, cyc = 0, cnt, n_lr = 0;
  assign dec = {3'h0, l8, il, lat, rec, es, rsv, tm, lr};
  dmw_ctl_model dmw_ctl_model_i (.mclk_in(clk), .stall_in(stall),
    .load_out(ld), .word_out(word), .rd_out(rd), .wr_out(wr), .ap_out(ap),
    .col_out(col), .ready_out(rdy));
  dmw_mode_decode #(.FAST_EXIT(FAST), .SLOW_EXIT(SLOW)) dmw_mode_decode_i (
    .mclk_in(clk), .reset_in(rst), .load_mode_command_in(ld),
    .mode_setting_word_in(word), .additive_latency_in(al), .read_cmd_in(rd),
    .write_cmd_in(wr), .auto_precharge_in(ap), .col_addr_in(col),
    .col_ready_in(rdy), .power_down_in(pd), .banks_idle_in(idle),
    .col_valid_out(cv), .col_beat_out(beat), .read_data_start_out(rds),
    .precharge_out(pre), .loop_reset_out(lr), .test_mode_out(tm),
    .burst_len8_out(l8), .interleave_out(il), .read_latency_cycles_out(lat),
    .recovery_cycles_out(rec), .exit_slow_out(es), .low_power_state_out(lps),
    .exit_busy_out(eb), .mode_reserved_out(rsv));
  // Clock at 200 MHz.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Collects accepted beats and loop reset pulses; cuts a hang short.
  always @(posedge clk) begin
    if (cv === 1'b1 && rdy === 1'b1) q.push_back(beat);
    if (lr === 1'b1) n_lr++;
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      summarize();
    end
  end
  function automatic logic [16:0] mw(input logic [2:0] len, input logic ord,
    input logic [2:0] lt, input logic [2:0] rc, input logic ex);
    return {4'h0, ex, rc, 2'b00, lt, ord, len};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_beats(input int n);
    cnt = 0;
    while (q.size() < n && cnt < 100) begin
      @(negedge clk);
      cnt++;
    end
    repeat (3) @(negedge clk);
    chk(q.size(), n);
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    rst = 1'b1;
    pd = 1'b0;
    idle = 1'b0;
    stall = 1'b0;
    al = 3'h0;
    repeat (10) @(negedge clk);
    chk(dec, {3'h0, 2'b00, 3'h3, 4'h2, 4'h0});
    rst = 1'b0;
    for (int i = 0; i < 7; i++) begin
      dmw_ctl_model_i.load(mw(i[2] ? 3'h3 : 3'h2, i[1], 3'(3 + i % 5),
        3'(i + 1), i[0]));
      chk(dec, {3'h0, i[2], i[1], 3'(3 + i % 5), 4'(i + 2), i[0],
        3'h0});
    end
    dmw_ctl_model_i.load(mw(3'h5, 1'b0, 3'h0, 3'h0, 1'b0));
    chk(dec, {3'h0, 2'b00, 3'h3, 4'h2, 1'b0, 1'b1, 2'b00});
    $display("test decode done");
    dmw_ctl_model_i.load(mw(3'h3, 1'b1, 3'h5, 3'h4, 1'b0));
    n_lr = 0;
    dmw_ctl_model_i.load(mw(3'h3, 1'b1, 3'h5, 3'h4, 1'b0) | 17'h00100);
    chk(n_lr, 1);
    // Deliberately selects the test mode, which a controller must not do.
    dmw_ctl_model_i.load(mw(3'h2, 1'b0, 3'h3, 3'h1, 1'b1) | 17'h00180);
    chk(n_lr, 1);
    chk(dec, {3'h0, 2'b11, 3'h5, 4'h5, 2'h0, 1'b1, 1'b0});
    dmw_ctl_model_i.load(mw(3'h2, 1'b0, 3'h3, 3'h1, 1'b0));
    chk(tm, 1'b0);
    $display("test loop reset and test mode done");
    for (int m = 0; m < 4; m++) begin
      dmw_ctl_model_i.load(mw(m[0] ? 3'h3 : 3'h2, m[1], 3'h3, 3'h1, 1'b0));
      for (int s = 0; s < 8; s++) begin
        stall = s[1];
        q.delete();
        dmw_ctl_model_i.col_cmd(s[0], 1'b0, {7'h55, 3'(s)});
        wait_beats(m[0] ? 8 : 4);
        for (int k = 0; k < q.size(); k++) begin
          b = 3'(k);
          lo = m[1] ? 3'(s) ^ b : {s[2] ^ b[2], 2'(s) + b[1:0]};
          chk(q[k], {s[0], k == q.size() - 1, 7'h55, lo});
        end
      end
    end
    stall = 1'b0;
    $display("test burst order done");
    for (int l = 3; l < 8; l++) begin
      for (int a = 0; a < 4; a += 3) begin
        dmw_ctl_model_i.load(mw(3'h2, 1'b0, 3'(l), 3'h1, 1'b0));
        al = 3'(a);
        q.delete();
        dmw_ctl_model_i.col_cmd(1'b0, 1'b0, 10'h000);
        cnt = 0;
        while (rds !== 1'b1 && cnt < 40) begin
          @(negedge clk);
          cnt++;
        end
        chk(cnt, l + a);
        wait_beats(4);
      end
    end
    al = 3'h0;
    $display("test read latency done");
    for (int r = 1; r < 8; r += 6) begin
      dmw_ctl_model_i.load(mw(3'h2, 1'b0, 3'h3,
        dmw_ctl_model_i.wr_code(5 * r + 3), 1'b0));
      dmw_ctl_model_i.col_cmd(1'b1, 1'b1, 10'h001);
      cnt = 0;
      while (!(cv === 1'b1 && beat.last === 1'b1) && cnt < 40) begin
        @(negedge clk);
        cnt++;
      end
      cnt = 0;
      while (pre !== 1'b1 && cnt < 40) begin
        @(negedge clk);
        cnt++;
      end
      chk(cnt, r + 1);
    end
    $display("test write recovery done");
    for (int k = 0; k < 4; k++) begin
      dmw_ctl_model_i.load(mw(3'h2, 1'b0, 3'h3, 3'h1, k[0]));
      idle = k[1];
      pd = 1'b1;
      repeat (4) @(negedge clk);
      chk(lps, k[0] & !k[1]);
      pd = 1'b0;
      cnt = 0;
      repeat (12) begin
        @(negedge clk);
        if (eb === 1'b1) cnt++;
      end
      chk(cnt, k[1] ? 0 : (k[0] ? SLOW : FAST));
    end
    $display("test power-down exit done");
    summarize();
  end
endmodule
`default_nettype wire
